// ### shared/eeid_defines.vh
// Purpose: constants for the identification-page lock and power-state block
// Assumes: 20 MHz system clock, SPI mode 0 on the serial pins
// Notes: instruction codes and register offsets are local choices
// Functional notes
// - lock status byte carries the lock state in bit 0
// - lock status byte repeats while selected, no address advance
// - deselect ends the read, output released, engine idle
// - lock status read ignored while a write cycle runs
// - successful lock makes the identification page read-only forever
// - only bit 1 of the lock data byte is checked
// - lock runs only if deselect lands on a data byte boundary
// - valid lock starts a timed write cycle with busy flag set
// - lock dropped when busy, both protect bits set, or protocol check fails
// - all instructions ignored while power-on reset is active
// - power-on reset clears enable latch and busy while active, keeps protect bits
// - supply drop to threshold resets and locks out the device
// - serial output driven only while selected, released otherwise
// - reads correct a single bad bit in each aligned four-byte group
// - byte write rewrites the whole four-byte group with fresh check bits
// - delivered with bytes other than the identification code at FFh and protect and disable bits clear
// - first three identification bytes hold the identification code
// - identification access uses page select low and six low address bits
`ifndef EEID_DEFINES_VH
`define EEID_DEFINES_VH
`define EEID_OP_READ     8'h83
`define EEID_OP_WRITE    8'h82
`define EEID_SEL_BIT     2
`define EEID_LOCK_BIT    1
`define EEID_CLK_NS      50
`define EEID_TW_NS       4000000
`define EEID_TW_W        17
`define EEID_BLANK       8'hFF
`define EEID_IDENT0      8'h5A
`define EEID_IDENT1      8'h3C
`define EEID_IDENT2      8'h11
`define EEID_REG_CTRL    8'h00
`define EEID_REG_STAT    8'h04
`define EEID_CTRL_WEL    0
`define EEID_CTRL_BPLO   1
`define EEID_CTRL_BPHI   2
`define EEID_CTRL_STATUS_WRITE_DISABLE_BIT   3
`define EEID_STAT_LOCK   0
`define EEID_STAT_BUSY   1
`define EEID_STAT_WEL    2
`define EEID_STAT_POR    3
`endif

// ### src/eeid_core.v
// Purpose: identification-page lock, lock status and power-state engine
// Assumes: SPI pins and power-on-reset level are asynchronous to clk_i
// Notes: page write keeps only the last byte received before deselect
//
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "eeid_defines.vh"
module eeid_core #(
    parameter TW_CYCLES = `EEID_TW_NS / `EEID_CLK_NS
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_sel_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    output reg         wb_ack_o,
    input  wire        por_i,
    input  wire        pick_n_i,
    input  wire        sclk_i,
    input  wire        serial_in_i,
    output reg         serial_out_o,
    output reg         serial_out_oe_o
);
    localparam ST_IDLE  = 3'd0;
    localparam ST_CMD   = 3'd1;
    localparam ST_ADDR  = 3'd2;
    localparam ST_RDATA = 3'd3;
    localparam ST_WDATA = 3'd4;
    localparam ST_SKIP  = 3'd5;

    // syndrome coding: data bit i maps to {2'b11,i}, never a power of two
    function [6:0] ecc_chk;
        input [31:0] d;
        integer      i;
        begin
            ecc_chk = 7'h00;
            for (i = 0; i < 32; i = i + 1) begin
                if (d[i])
                    ecc_chk = ecc_chk ^ {2'b11, i[4:0]};
            end
        end
    endfunction

    function [31:0] ecc_fix;
        input [31:0] d;
        input [6:0]  c;
        reg   [6:0]  s;
        begin
            s = ecc_chk(d) ^ c;
            ecc_fix = d;
            if (s[6:5] == 2'b11)
                ecc_fix[s[4:0]] = ~d[s[4:0]];
        end
    endfunction

    // delivered check bits, fixed at elaboration so the reset branch loads constants only
    localparam [6:0] CHK_IDENT = ecc_chk({`EEID_BLANK, `EEID_IDENT2, `EEID_IDENT1, `EEID_IDENT0});
    localparam [6:0] CHK_BLANK = ecc_chk({4{`EEID_BLANK}});

    reg  [7:0]  mem_ff [0:63];
    reg  [6:0]  chk_ff [0:15];
    reg  [2:0]  pick_s_ff, sclk_s_ff;
    reg  [1:0]  sin_s_ff, por_s_ff;
    reg  [2:0]  state_ff;
    reg  [2:0]  cnt_ff;
    reg  [7:0]  sh_ff, out_sh_ff, wbyte_ff;
    reg  [5:0]  addr_ff, waddr_ff;
    reg         is_wr_ff, sel_ff, abyte_ff, got_ff;
    reg         lock_ff, busy_ff, wel_ff, bp_lo_ff, bp_hi_ff, status_write_disable_bit_ff;
    reg         pend_lock_ff;
    reg  [`EEID_TW_W-1:0] tw_cnt_ff;
    integer     k;

    wire        pick_hi   = pick_s_ff[1];
    wire        cs_rise   = pick_s_ff[1] & ~pick_s_ff[2];
    wire        sck_rise  = sclk_s_ff[1] & ~sclk_s_ff[2];
    wire        sck_fall  = ~sclk_s_ff[1] & sclk_s_ff[2];
    wire        sin       = sin_s_ff[1];
    wire        por_on    = por_s_ff[1];
    wire [7:0]  in_byte   = {sh_ff[6:0], sin};
    wire        byte_done = sck_rise & (cnt_ff == 3'd7);
    wire        wb_hit    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wb_wr     = wb_hit & wb_we_i & (wb_adr_i == `EEID_REG_CTRL) & wb_sel_i[0];
    wire        tw_end    = busy_ff & (tw_cnt_ff == {`EEID_TW_W{1'b0}});
    wire [31:0] wgrp_raw  = {mem_ff[{waddr_ff[5:2], 2'd3}], mem_ff[{waddr_ff[5:2], 2'd2}],
                             mem_ff[{waddr_ff[5:2], 2'd1}], mem_ff[{waddr_ff[5:2], 2'd0}]};
    wire [31:0] rgrp_raw  = {mem_ff[{addr_ff[5:2], 2'd3}], mem_ff[{addr_ff[5:2], 2'd2}],
                             mem_ff[{addr_ff[5:2], 2'd1}], mem_ff[{addr_ff[5:2], 2'd0}]};
    reg  [31:0] wgrp_new;
    reg  [31:0] rgrp_fix;
    reg  [7:0]  rd_byte;
    reg         start_ok;

    always @* begin
        rgrp_fix = ecc_fix(rgrp_raw, chk_ff[addr_ff[5:2]]);
        rd_byte  = rgrp_fix[{addr_ff[1:0], 3'd0} +: 8];
    end

    always @* begin
        wgrp_new = ecc_fix(wgrp_raw, chk_ff[waddr_ff[5:2]]);
        wgrp_new[{waddr_ff[1:0], 3'd0} +: 8] = wbyte_ff;
    end

    // boundary check; busy, protect and latch checks; locked page
    always @* begin
        start_ok = cs_rise & (state_ff == ST_WDATA) & (cnt_ff == 3'd0) & got_ff & ~busy_ff
                   & ~(bp_hi_ff & bp_lo_ff) & wel_ff & ~por_on;
        if (!sel_ff && lock_ff)
            start_ok = 1'b0;
        if (sel_ff && !wbyte_ff[`EEID_LOCK_BIT])
            start_ok = 1'b0;
    end

    // pins cross into clk_i; only the second stage and later are read
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pick_s_ff <= 3'b111;
            sclk_s_ff <= 3'b000;
            sin_s_ff  <= 2'b00;
            por_s_ff  <= 2'b11;
        end else begin
            pick_s_ff <= {pick_s_ff[1:0], pick_n_i};
            sclk_s_ff <= {sclk_s_ff[1:0], sclk_i};
            sin_s_ff  <= {sin_s_ff[0], serial_in_i};
            por_s_ff  <= {por_s_ff[0], por_i};
        end
    end

    // serial instruction engine
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff        <= ST_IDLE;
            cnt_ff          <= 3'd0;
            sh_ff           <= 8'h00;
            out_sh_ff       <= 8'h00;
            addr_ff         <= 6'd0;
            is_wr_ff        <= 1'b0;
            sel_ff          <= 1'b0;
            abyte_ff        <= 1'b0;
            got_ff          <= 1'b0;
            wbyte_ff        <= 8'h00;
            waddr_ff        <= 6'd0;
            serial_out_o    <= 1'b0;
            serial_out_oe_o <= 1'b0;
        // nothing decoded under power-on reset; lockout
        end else if (por_on || pick_hi) begin
            // deselect ends the transfer; output released
            state_ff        <= ST_IDLE;
            serial_out_oe_o <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    state_ff <= ST_CMD;
                    cnt_ff   <= 3'd0;
                    abyte_ff <= 1'b0;
                    got_ff   <= 1'b0;
                end
                ST_CMD: if (sck_rise) begin
                    sh_ff  <= in_byte;
                    cnt_ff <= cnt_ff + 3'd1;
                    if (byte_done) begin
                        is_wr_ff <= (in_byte == `EEID_OP_WRITE);
                        // reads refused during a write cycle
                        // writes refused too, so a pending byte and address stay intact
                        if ((in_byte == `EEID_OP_WRITE || in_byte == `EEID_OP_READ) && !busy_ff)
                            state_ff <= ST_ADDR;
                        else
                            state_ff <= ST_SKIP;
                    end
                end
                ST_ADDR: if (sck_rise) begin
                    sh_ff  <= in_byte;
                    cnt_ff <= cnt_ff + 3'd1;
                    if (byte_done && !abyte_ff) begin
                        abyte_ff <= 1'b1;
                        // page select taken, other upper bits ignored
                        sel_ff   <= in_byte[`EEID_SEL_BIT];
                    end else if (byte_done) begin
                        // six low bits pick the byte
                        addr_ff  <= in_byte[5:0];
                        state_ff <= is_wr_ff ? ST_WDATA : ST_RDATA;
                    end
                end
                ST_RDATA: begin
                    // first load one cycle after address, before first falling edge
                    if (cnt_ff == 3'd0 && !serial_out_oe_o) begin
                        out_sh_ff       <= sel_ff ? {7'h00, lock_ff} : rd_byte;
                        serial_out_oe_o <= 1'b1;
                    end else if (sck_fall) begin
                        serial_out_o <= out_sh_ff[7];
                        cnt_ff       <= cnt_ff + 3'd1;
                        if (cnt_ff == 3'd7) begin
                            if (sel_ff) begin
                                out_sh_ff <= {7'h00, lock_ff};
                            end else begin
                                out_sh_ff <= 8'h00;
                                addr_ff   <= addr_ff + 6'd1;
                            end
                        end else begin
                            out_sh_ff <= {out_sh_ff[6:0], 1'b0};
                        end
                    end else if (cnt_ff == 3'd0 && !sel_ff && out_sh_ff == 8'h00) begin
                        out_sh_ff <= rd_byte;
                    end
                end
                ST_WDATA: if (sck_rise) begin
                    sh_ff  <= in_byte;
                    cnt_ff <= cnt_ff + 3'd1;
                    if (byte_done) begin
                        // lock byte kept whole, only bit 1 judged later
                        wbyte_ff <= in_byte;
                        waddr_ff <= addr_ff;
                        got_ff   <= 1'b1;
                        addr_ff  <= addr_ff + 6'd1;
                    end
                end
                ST_SKIP: state_ff <= ST_SKIP;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // write cycle timer, lock and nonvolatile page store
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_ff      <= 1'b0;
            tw_cnt_ff    <= {`EEID_TW_W{1'b0}};
            pend_lock_ff <= 1'b0;
            lock_ff      <= 1'b0;
            for (k = 0; k < 64; k = k + 1)
                mem_ff[k] <= `EEID_BLANK;
            mem_ff[0] <= `EEID_IDENT0;
            mem_ff[1] <= `EEID_IDENT1;
            mem_ff[2] <= `EEID_IDENT2;
            chk_ff[0] <= CHK_IDENT;
            for (k = 1; k < 16; k = k + 1)
                chk_ff[k] <= CHK_BLANK;
        end else if (por_on) begin
            busy_ff   <= 1'b0;
            tw_cnt_ff <= {`EEID_TW_W{1'b0}};
        end else if (start_ok) begin
            busy_ff      <= 1'b1;
            tw_cnt_ff    <= TW_CYCLES[`EEID_TW_W-1:0] - {{(`EEID_TW_W-1){1'b0}}, 1'b1};
            pend_lock_ff <= sel_ff;
        end else if (tw_end) begin
            busy_ff <= 1'b0;
            if (pend_lock_ff) begin
                lock_ff <= 1'b1;
            end else begin
                for (k = 0; k < 4; k = k + 1)
                    mem_ff[{waddr_ff[5:2], k[1:0]}] <= wgrp_new[k*8 +: 8];
                chk_ff[waddr_ff[5:2]] <= ecc_chk(wgrp_new);
            end
        end else if (busy_ff) begin
            tw_cnt_ff <= tw_cnt_ff - {{(`EEID_TW_W-1){1'b0}}, 1'b1};
        end
    end

    // register slave, one wait state, unmapped reads return zero
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            wel_ff   <= 1'b0;
            bp_lo_ff <= 1'b0;
            bp_hi_ff <= 1'b0;
            status_write_disable_bit_ff  <= 1'b0;
        end else begin
            wb_ack_o <= wb_hit;
            if (wb_wr) begin
                // software write beats the hardware clear below
                wel_ff   <= wb_dat_i[`EEID_CTRL_WEL];
                bp_lo_ff <= wb_dat_i[`EEID_CTRL_BPLO];
                bp_hi_ff <= wb_dat_i[`EEID_CTRL_BPHI];
                status_write_disable_bit_ff  <= wb_dat_i[`EEID_CTRL_STATUS_WRITE_DISABLE_BIT];
            end else if (por_on || start_ok) begin
                wel_ff <= 1'b0;
            end
            wb_dat_o <= 32'h00000000;
            if (wb_hit && !wb_we_i && wb_adr_i == `EEID_REG_CTRL) begin
                wb_dat_o[`EEID_CTRL_WEL]  <= wel_ff;
                wb_dat_o[`EEID_CTRL_BPLO] <= bp_lo_ff;
                wb_dat_o[`EEID_CTRL_BPHI] <= bp_hi_ff;
                wb_dat_o[`EEID_CTRL_STATUS_WRITE_DISABLE_BIT] <= status_write_disable_bit_ff;
            end else if (wb_hit && !wb_we_i && wb_adr_i == `EEID_REG_STAT) begin
                wb_dat_o[`EEID_STAT_LOCK] <= lock_ff;
                wb_dat_o[`EEID_STAT_BUSY] <= busy_ff;
                wb_dat_o[`EEID_STAT_WEL]  <= wel_ff;
                wb_dat_o[`EEID_STAT_POR]  <= por_on;
            end
        end
    end
endmodule

// ### testbench/eeid_asserts.sv
// Purpose: port-level checks for the id-page lock and power-state engine
// Assumes: one clock domain, rst_i async active high
// Notes: lock_seen_ff follows what software has already read back
`timescale 1ns/1ps
module eeid_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        por_i,
    input wire logic        pick_n_i,
    input wire logic        sclk_i,
    input wire logic        serial_in_i,
    input wire logic        serial_out_o,
    input wire logic        serial_out_oe_o
);
    logic lock_seen_ff;
    wire  stat_rd = wb_ack_o && !wb_we_i && wb_adr_i == 8'h04;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            lock_seen_ff <= 1'b0;
        else if (stat_rd && wb_dat_o[0])
            lock_seen_ff <= 1'b1;
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // three edges of synchroniser and output register, one spare
    sequence s_desel;
        pick_n_i [*5];
    endsequence

    a_ack_latency: assert property (s_req |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_unmapped_zero: assert property (s_req ##0 (!wb_we_i && wb_adr_i != 8'h00 && wb_adr_i != 8'h04)
        |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    a_oe_release: assert property (s_desel |-> !serial_out_oe_o)
        else $error("serial output driven while deselected");
    a_por_silent: assert property (por_i [*4] |-> !serial_out_oe_o)
        else $error("serial output driven under power-on reset");
    a_oe_needs_select: assert property ($rose(serial_out_oe_o) |-> !pick_n_i && $past(!pick_n_i, 3))
        else $error("serial output enabled without select");
    a_lock_sticky: assert property (stat_rd && lock_seen_ff |-> wb_dat_o[0])
        else $error("lock bit reads clear after being set");
endmodule

bind eeid_core eeid_asserts eeid_asserts_i (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .por_i(por_i),
    .pick_n_i(pick_n_i), .sclk_i(sclk_i), .serial_in_i(serial_in_i),
    .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o));

// ### testbench/eeid_spi_master.sv
// Purpose: mode 0 serial bus master driving the engine's select, clock and data
// Assumes: link clock free of the system clock, 400 ns period
// Notes: clock stands low between frames; read bits taken late in the high phase
`timescale 1ns/1ps
module eeid_spi_master #(
    parameter HALF_NS = 200
) (
    output logic      pick_n_o,
    output logic      sclk_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    initial begin
        pick_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end

    task automatic frame(input logic [47:0] tx, input int nbits, output logic [23:0] rx);
        int i;
        rx = 24'h0;
        // odd offset keeps link phase unrelated to clk_i
        #(HALF_NS + 37) pick_n_o = 1'b0;
        #(HALF_NS);
        for (i = 0; i < nbits; i++) begin
            mosi_o = tx[47 - i];
            #(HALF_NS) sclk_o = 1'b1;
            #(HALF_NS) rx = {rx[22:0], miso_i};
            sclk_o = 1'b0;
        end
        #(HALF_NS) pick_n_o = 1'b1;
        #(HALF_NS * 5);
    endtask
endmodule

// ### testbench/tb_eeid_core.sv
// Purpose: self-checking bench for the id-page lock and power-state engine
// Assumes: Wishbone classic master here, serial master in its own module
// Notes: write cycle shortened to 400 clocks
`timescale 1ns/1ps
`include "eeid_defines.vh"
module tb_eeid_core;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic        wb_we_i = 1'b0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        por_i = 1'b0;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, pick_n, sclk, mosi, serial_out_o, serial_out_oe_o;
    logic        q_last = 1'b0;
    int          oe_cnt = 0, n_mismatch = 0, checks = 0, k;
    logic [31:0] rd;
    logic [23:0] rx;
    // released line shows the inverse of its last level
    wire         miso = serial_out_oe_o ? serial_out_o : ~q_last;

    always #25 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        if (serial_out_oe_o) begin
            oe_cnt <= oe_cnt + 1;
            q_last <= serial_out_o;
        end
    end

    eeid_core #(.TW_CYCLES(400)) eeid_core_i (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .por_i(por_i),
        .pick_n_i(pick_n), .sclk_i(sclk), .serial_in_i(mosi), .serial_out_o(serial_out_o),
        .serial_out_oe_o(serial_out_oe_o));
    eeid_spi_master eeid_spi_master_i (.pick_n_o(pick_n), .sclk_o(sclk), .mosi_o(mosi), .miso_i(miso));

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_adr_i <= a;
        wb_we_i <= we;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        // registered ack: seen high at the second edge after the request rises
        cmp("ack wait", 32'h2, n);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            wb(8'h04, 1'b0, 32'h0, rd);
            n++;
        end while (rd[1] !== 1'b0 && n < 300);
        cmp("busy end", 32'h0, {31'h0, rd[1]});
    endtask

    task automatic lock_read;
        eeid_spi_master_i.frame({8'h83, 8'h04, 8'h00, 24'h0}, 40, rx);
    endtask

    task report_and_stop;
        $display("checks %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #3000000;
        n_mismatch++;
        report_and_stop;
    end

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        eeid_spi_master_i.frame({8'h83, 8'h00, 8'h00, 24'h0}, 48, rx);
        cmp("ident", {8'h0, `EEID_IDENT0, `EEID_IDENT1, `EEID_IDENT2}, {8'h0, rx});
        lock_read;
        cmp("lock byte", 32'h0, {16'h0, rx[15:0]});
        cmp("oe idle", 32'h0, {31'h0, serial_out_oe_o});
        wb(8'h08, 1'b0, 32'h0, rd);
        cmp("unmapped", 32'h0, rd);
        wb(8'h00, 1'b1, 32'h1, rd);
        eeid_spi_master_i.frame({8'h82, 8'h00, 8'h03, 8'h77, 16'h0}, 32, rx);
        wait_idle;
        eeid_spi_master_i.frame({8'h83, 8'h00, 8'h03, 24'h0}, 32, rx);
        cmp("id byte", 32'h77, {24'h0, rx[7:0]});
        for (k = 0; k < 4; k++) begin
            wb(8'h00, 1'b1, (k == 2) ? 32'h7 : (k == 3) ? 32'h0 : 32'h1, rd);
            eeid_spi_master_i.frame({8'h82, 8'h04, 8'h00, (k == 0) ? 8'hFD : 8'hFE, 16'hFFFF},
                (k == 1) ? 36 : 32, rx);
            wb(8'h04, 1'b0, 32'h0, rd);
            cmp("dropped lock", 32'h0, {30'h0, rd[1:0]});
        end
        wb(8'h00, 1'b1, 32'h1, rd);
        eeid_spi_master_i.frame({8'h82, 8'h04, 8'h00, 8'hFE, 16'h0}, 32, rx);
        wb(8'h04, 1'b0, 32'h0, rd);
        cmp("lock started", 32'h2, {29'h0, rd[2:0]});
        k = oe_cnt;
        lock_read;
        cmp("oe while busy", k, oe_cnt);
        wait_idle;
        cmp("lock set", 32'h1, {31'h0, rd[0]});
        lock_read;
        cmp("lock byte", 32'h0101, {16'h0, rx[15:0]});
        wb(8'h00, 1'b1, 32'h1, rd);
        eeid_spi_master_i.frame({8'h82, 8'h00, 8'h03, 8'h88, 16'h0}, 32, rx);
        wait_idle;
        eeid_spi_master_i.frame({8'h83, 8'h00, 8'h03, 24'h0}, 32, rx);
        cmp("locked id byte", 32'h77, {24'h0, rx[7:0]});
        wb(8'h00, 1'b1, 32'hB, rd);
        por_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        wb(8'h04, 1'b0, 32'h0, rd);
        cmp("por flags", 32'h2, {30'h0, rd[3:2]});
        k = oe_cnt;
        lock_read;
        cmp("oe under por", k, oe_cnt);
        @(posedge clk_i);
        por_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        wb(8'h04, 1'b0, 32'h0, rd);
        cmp("status after por", 32'h1, {29'h0, rd[2:0]});
        wb(8'h00, 1'b0, 32'h0, rd);
        cmp("ctrl after por", 32'hA, {28'h0, rd[3:0]});
        report_and_stop;
    end
endmodule
